// ==== rtl/sec_pkg.sv ====
// Package for the scan event counter bank: register map, command word
// layout, operation codes, count limits and controller states.
// Assumes a 32-bit AHB-Lite slave decoding the low address byte.
package sec_pkg;

   localparam int SLOTS  = 256;
   localparam int SLOT_W = 8;
   localparam int CNT_W  = 16;
   localparam int ADDR_W = 8;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_OP     = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_PRESET = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_SEL    = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_LAST   = 8'h10;

   // Command word fields
   localparam int OP_SLOT_LSB = 0;
   localparam int OP_CODE_LSB = 8;
   localparam int OP_CODE_W   = 4;
   localparam int OP_CU_BIT   = 16;
   localparam int OP_CD_BIT   = 17;
   localparam int OP_LOAD_BIT = 18;
   localparam int OP_WIPE_BIT = 19;

   // Status word fields
   localparam int ST_FLAG_BIT = 16;
   localparam int ST_ATP_BIT  = 17;
   localparam int ST_ATZ_BIT  = 18;
   localparam int ST_RDY_BIT  = 19;

   // Operation codes
   localparam logic [OP_CODE_W-1:0] OPC_NONE  = 4'h0;
   localparam logic [OP_CODE_W-1:0] OPC_F1_UP = 4'h1;
   localparam logic [OP_CODE_W-1:0] OPC_F1_DN = 4'h2;
   localparam logic [OP_CODE_W-1:0] OPC_F1_UD = 4'h3;
   localparam logic [OP_CODE_W-1:0] OPC_F2_UP = 4'h4;
   localparam logic [OP_CODE_W-1:0] OPC_F2_DN = 4'h5;
   localparam logic [OP_CODE_W-1:0] OPC_F2_UD = 4'h6;
   localparam logic [OP_CODE_W-1:0] OPC_RESET = 4'h7;

   localparam logic [CNT_W-1:0] CNT_MAX    = 16'h7fff;
   localparam logic [CNT_W-1:0] CNT_MIN    = 16'h8000;
   localparam logic [CNT_W-1:0] CNT_ZERO   = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE    = 16'h0001;
   localparam logic [CNT_W-1:0] PRESET_RST = 16'h0000;

   localparam logic [SLOT_W-1:0] SYNC_CYCLES = 8'h02;

   typedef enum logic [2:0] {
      ST_WAIT  = 3'b001,
      ST_SWEEP = 3'b010,
      ST_RUN   = 3'b100
   } sec_state_t;

endpackage

// ==== rtl/sec_eval.sv ====
// Next-state evaluation of one counter slot for one scan operation.
// Purely combinational; the caller supplies edges already detected.
`timescale 1ns/1ps
`default_nettype none

module sec_eval (
   input  wire logic [3:0]  opCode,       // Operation code
   input  wire logic [15:0] count,        // Current count value
   input  wire logic [15:0] preset,       // Preset limit
   input  wire logic        upEdge,       // Count-up rising edge
   input  wire logic        downEdge,     // Count-down rising edge
   input  wire logic        load,         // Load preset input
   input  wire logic        wipe,         // Wipe input
   input  wire logic        curFlag,      // Stored counter flag
   input  wire logic        curAtPreset,  // Stored at-preset flag
   input  wire logic        curAtZero,    // Stored at-zero flag
   output logic [15:0]      nextCount,    // New count value
   output logic             nextFlag,     // New counter flag
   output logic             nextAtPreset, // New at-preset flag
   output logic             nextAtZero    // New at-zero flag
);

   wire logic signed [15:0] cnt  = $signed(count);
   wire logic signed [15:0] pv   = $signed(preset);
   wire logic signed [15:0] zero = $signed(sec_pkg::CNT_ZERO);
   wire logic onlyUp   = upEdge & ~downEdge;
   wire logic onlyDown = downEdge & ~upEdge;
   wire logic incOk    = cnt < pv;
   wire logic decOk    = cnt > zero;

   always_comb begin
      nextCount    = count;
      nextFlag     = curFlag;
      nextAtPreset = curAtPreset;
      nextAtZero   = curAtZero;
      case (opCode)
         sec_pkg::OPC_F1_UP: begin
            if (wipe) begin
               nextCount = sec_pkg::CNT_ZERO;
            end else if (upEdge && count != sec_pkg::CNT_MAX) begin
               nextCount = count + sec_pkg::CNT_ONE;
            end
            nextFlag = ~wipe & ($signed(nextCount) >= pv);
         end
         sec_pkg::OPC_F1_DN: begin
            if (wipe) begin
               nextCount = sec_pkg::CNT_ZERO;
               nextFlag  = 1'b0;
            end else if (load) begin
               nextCount = preset;
               nextFlag  = 1'b0;
            end else begin
               if (downEdge && decOk) begin
                  nextCount = count - sec_pkg::CNT_ONE;
               end
               nextFlag = nextCount == sec_pkg::CNT_ZERO;
            end
         end
         sec_pkg::OPC_F1_UD: begin
            if (wipe) begin
               nextCount = sec_pkg::CNT_ZERO;
            end else if (onlyUp) begin
               nextCount = count + sec_pkg::CNT_ONE;
            end else if (onlyDown) begin
               nextCount = count - sec_pkg::CNT_ONE;
            end
            nextFlag = ~wipe & ($signed(nextCount) >= pv);
         end
         sec_pkg::OPC_F2_UP: begin
            if (wipe) begin
               nextCount = sec_pkg::CNT_ZERO;
            end else if (upEdge && incOk) begin
               nextCount = count + sec_pkg::CNT_ONE;
            end
            nextFlag = $signed(nextCount) >= pv;
         end
         sec_pkg::OPC_F2_DN: begin
            if (load) begin
               nextCount = preset;
            end else if (downEdge && decOk) begin
               nextCount = count - sec_pkg::CNT_ONE;
            end
            nextFlag = nextCount == sec_pkg::CNT_ZERO;
         end
         sec_pkg::OPC_F2_UD: begin
            if (wipe) begin
               nextCount = sec_pkg::CNT_ZERO;
            end else if (load) begin
               nextCount = preset;
            end else if (onlyUp && incOk) begin
               nextCount = count + sec_pkg::CNT_ONE;
            end else if (onlyDown && decOk) begin
               nextCount = count - sec_pkg::CNT_ONE;
            end
            nextAtPreset = nextCount == preset;
            nextAtZero   = nextCount == sec_pkg::CNT_ZERO;
         end
         sec_pkg::OPC_RESET: begin
            nextCount = sec_pkg::CNT_ZERO;
            nextFlag  = 1'b0;
         end
         default: begin
         end
      endcase
   end

endmodule

`default_nettype wire

// ==== rtl/sec_scan_counters.sv ====
// Bank of numbered 16-bit scan event counters behind an AHB-Lite slave.
// Assumes one bus master, single word transfers, and a retention strap pin.
//
// Contract
// - An up counter of the first family adds one on each rising count-up edge.
// - First-family up and up/down flags are on when count is at least the preset.
// - The first-family up counter holds at 32767.
// - First-family wipe or the reset operation clears the flag and zeroes the count.
// - The first-family down counter subtracts on edges, stops at zero, flags zero.
// - Load on the first-family down counter clears the flag and copies the preset.
// - The first-family up/down counter wraps between 32767 and -32768.
// - The first-family up/down flag is recompared on every evaluation.
// - After power-up all flags are off and counts are cleared unless retained.
// - Slots 0 to 255 exist and every variant on a slot shares its count.
// - The second-family up counter counts rising edges and flags count at or above preset.
// - The second-family up counter stops at the preset and zeroes on wipe.
// - The second-family down counter stops at zero, flags zero, and reloads on load.
// - The second-family up/down counter flags count equal preset and count equal zero.
// - The second-family up/down load copies the preset and wipe zeroes the count.
// - The second-family up/down counter stops at the preset or zero.
`timescale 1ns/1ps
`default_nettype none

module sec_scan_counters #(
   parameter int SLOTS = sec_pkg::SLOTS // Number of counter slots
) (
   input  wire logic        clock,         // 200 MHz clock
   input  wire logic        sys_rst,       // Synchronous reset, high
   input  wire logic        retainCounts,  // Strap: keep counts over reset
   input  wire logic        hsel,          // AHB select
   input  wire logic [31:0] haddr,         // AHB address
   input  wire logic [1:0]  htrans,        // AHB transfer type
   input  wire logic        hwrite,        // AHB write
   input  wire logic [2:0]  hsize,         // AHB size, word only
   input  wire logic [31:0] hwdata,        // AHB write data
   input  wire logic        hready,        // AHB bus ready
   output logic             hreadyout,     // AHB slave ready
   output logic             hresp,         // AHB response, always OKAY
   output logic [31:0]      hrdata         // AHB read data
);

   localparam int SW = $clog2(SLOTS);

   function automatic logic [31:0] packStatus(input logic [15:0] c, input logic f,
                                              input logic p, input logic z, input logic r);
      logic [31:0] w;
      w = '0;
      w[sec_pkg::CNT_W-1:0]        = c;
      w[sec_pkg::ST_FLAG_BIT]      = f;
      w[sec_pkg::ST_ATP_BIT]       = p;
      w[sec_pkg::ST_ATZ_BIT]       = z;
      w[sec_pkg::ST_RDY_BIT]       = r;
      return w;
   endfunction

   // Storage shared by all variants of a slot
   logic [15:0]      countMem [SLOTS];
   logic [SLOTS-1:0] flagMem;
   logic [SLOTS-1:0] atpMem;
   logic [SLOTS-1:0] atzMem;
   logic [SLOTS-1:0] prevCu;
   logic [SLOTS-1:0] prevCd;

   logic [15:0] presetLimit;
   logic [SW-1:0] selSlot;
   logic [15:0] lastCount;
   logic        lastFlag;
   logic        lastAtPreset;
   logic        lastAtZero;

   sec_pkg::sec_state_t state;
   sec_pkg::sec_state_t next_state;
   logic [SW-1:0] sweepIdx;
   logic          retainMeta;
   logic          retainSync;

   // Bus pipeline
   logic                     wrPend;
   logic                     rdPend;
   logic                     rdDone;
   logic [sec_pkg::ADDR_W-1:0] dataAddr;

   wire logic running   = state == sec_pkg::ST_RUN;
   wire logic addrPhase = hsel & hready & htrans[1];
   wire logic opAddr    = dataAddr == sec_pkg::OFF_OP;
   wire logic wrStall   = wrPend & opAddr & ~running;
   wire logic rdStall   = rdPend & ~rdDone;
   assign hreadyout = ~(wrStall | rdStall);
   assign hresp     = 1'b0;
   wire logic wrDo  = wrPend & hreadyout;

   // Command decode
   wire logic [SW-1:0] opSlot = hwdata[sec_pkg::OP_SLOT_LSB +: SW];
   wire logic [3:0]    opCode = hwdata[sec_pkg::OP_CODE_LSB +: sec_pkg::OP_CODE_W];
   wire logic cuIn    = hwdata[sec_pkg::OP_CU_BIT];
   wire logic cdIn    = hwdata[sec_pkg::OP_CD_BIT];
   wire logic loadIn  = hwdata[sec_pkg::OP_LOAD_BIT];
   wire logic wipeIn  = hwdata[sec_pkg::OP_WIPE_BIT];
   wire logic opKnown = (opCode != sec_pkg::OPC_NONE) && (opCode <= sec_pkg::OPC_RESET);
   wire logic opFire  = wrDo & opAddr & opKnown;
   wire logic edgeOp  = opCode != sec_pkg::OPC_RESET;

   wire logic [15:0] curCount = countMem[opSlot];
   wire logic upEdge   = cuIn & ~prevCu[opSlot];
   wire logic downEdge = cdIn & ~prevCd[opSlot];

   logic [15:0] evCount;
   logic        evFlag;
   logic        evAtPreset;
   logic        evAtZero;

   sec_eval u_eval (
      .opCode       (opCode),
      .count        (curCount),
      .preset       (presetLimit),
      .upEdge       (upEdge),
      .downEdge     (downEdge),
      .load         (loadIn),
      .wipe         (wipeIn),
      .curFlag      (flagMem[opSlot]),
      .curAtPreset  (atpMem[opSlot]),
      .curAtZero    (atzMem[opSlot]),
      .nextCount    (evCount),
      .nextFlag     (evFlag),
      .nextAtPreset (evAtPreset),
      .nextAtZero   (evAtZero)
   );

   // Power-up sequencing
   wire logic waitDone  = sweepIdx == (sec_pkg::SYNC_CYCLES[SW-1:0] - 1'b1);
   wire logic sweepLast = sweepIdx == SW'(SLOTS - 1);
   wire logic sweepWr   = (state == sec_pkg::ST_SWEEP) & ~retainSync;

   always_comb begin
      next_state = state;
      case (state)
         sec_pkg::ST_WAIT:  if (waitDone) next_state = sec_pkg::ST_SWEEP;
         sec_pkg::ST_SWEEP: if (sweepLast) next_state = sec_pkg::ST_RUN;
         sec_pkg::ST_RUN:   next_state = sec_pkg::ST_RUN;
         default:           next_state = sec_pkg::ST_WAIT;
      endcase
   end

   always_ff @(posedge clock) begin
      retainMeta <= retainCounts;
      retainSync <= retainMeta;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state    <= sec_pkg::ST_WAIT;
         sweepIdx <= '0;
      end else begin
         state    <= next_state;
         sweepIdx <= (state != next_state) ? '0 : sweepIdx + 1'b1;
      end
   end

   // Counts are cleared by the sweep unless the strap retains them
   always_ff @(posedge clock) begin
      if (sweepWr) begin
         countMem[sweepIdx] <= sec_pkg::CNT_ZERO;
      end else if (opFire) begin
         countMem[opSlot] <= evCount;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         flagMem <= '0;
         atpMem  <= '0;
         atzMem  <= '0;
         prevCu  <= '0;
         prevCd  <= '0;
      end else if (opFire) begin
         flagMem[opSlot] <= evFlag;
         atpMem[opSlot]  <= evAtPreset;
         atzMem[opSlot]  <= evAtZero;
         if (edgeOp) begin
            prevCu[opSlot] <= cuIn;
            prevCd[opSlot] <= cdIn;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         lastCount    <= sec_pkg::CNT_ZERO;
         lastFlag     <= 1'b0;
         lastAtPreset <= 1'b0;
         lastAtZero   <= 1'b0;
      end else if (opFire) begin
         lastCount    <= evCount;
         lastFlag     <= evFlag;
         lastAtPreset <= evAtPreset;
         lastAtZero   <= evAtZero;
      end
   end

   // Bus pipeline and configuration registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         wrPend   <= 1'b0;
         rdPend   <= 1'b0;
         rdDone   <= 1'b0;
         dataAddr <= '0;
      end else begin
         rdDone <= rdStall;
         if (hreadyout) begin
            wrPend   <= addrPhase & hwrite;
            rdPend   <= addrPhase & ~hwrite;
            dataAddr <= haddr[sec_pkg::ADDR_W-1:0];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         presetLimit <= sec_pkg::PRESET_RST;
         selSlot     <= '0;
      end else if (wrDo) begin
         if (dataAddr == sec_pkg::OFF_PRESET) presetLimit <= hwdata[sec_pkg::CNT_W-1:0];
         if (dataAddr == sec_pkg::OFF_SEL) selSlot <= hwdata[SW-1:0];
      end
   end

   wire logic [31:0] statusWord = packStatus(countMem[selSlot], flagMem[selSlot],
                                             atpMem[selSlot], atzMem[selSlot], running);
   wire logic [31:0] lastWord   = packStatus(lastCount, lastFlag, lastAtPreset,
                                             lastAtZero, running);
   wire logic [31:0] presetWord = {16'h0000, presetLimit};
   wire logic [31:0] selWord    = 32'(selSlot);
   logic [31:0] readMux;

   always_comb begin
      case (dataAddr)
         sec_pkg::OFF_PRESET: readMux = presetWord;
         sec_pkg::OFF_SEL:    readMux = selWord;
         sec_pkg::OFF_STATUS: readMux = statusWord;
         sec_pkg::OFF_LAST:   readMux = lastWord;
         default:             readMux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         hrdata <= 32'h0000_0000;
      end else if (rdStall) begin
         hrdata <= readMux;
      end
   end

   // Checks on evaluated results and on power-up state
   AST_UP_INC: assert property (@(posedge clock) disable iff (sys_rst)
      opFire && opCode == sec_pkg::OPC_F1_UP && upEdge && !wipeIn
      && curCount != sec_pkg::CNT_MAX |=> lastCount == $past(curCount) + sec_pkg::CNT_ONE)
      else $error("up count did not add one");

   AST_UP_FLAG: assert property (@(posedge clock) disable iff (sys_rst)
      opFire && (opCode == sec_pkg::OPC_F1_UP || opCode == sec_pkg::OPC_F1_UD) && !wipeIn
      |=> lastFlag == ($signed(lastCount) >= $signed(presetLimit)))
      else $error("counter flag disagrees with preset compare");

   AST_UP_SAT: assert property (@(posedge clock) disable iff (sys_rst)
      opFire && opCode == sec_pkg::OPC_F1_UP && curCount == sec_pkg::CNT_MAX && !wipeIn
      |=> lastCount == sec_pkg::CNT_MAX)
      else $error("up counter passed its maximum");

   AST_WIPE: assert property (@(posedge clock) disable iff (sys_rst)
      opFire && (opCode == sec_pkg::OPC_RESET || (wipeIn && opCode == sec_pkg::OPC_F1_UD))
      |=> lastCount == sec_pkg::CNT_ZERO && !lastFlag)
      else $error("wipe did not clear counter");

   AST_DN_ZERO: assert property (@(posedge clock) disable iff (sys_rst)
      opFire && opCode == sec_pkg::OPC_F1_DN && !loadIn && !wipeIn
      |=> lastFlag == (lastCount == sec_pkg::CNT_ZERO))
      else $error("down flag disagrees with zero");

   AST_LOAD: assert property (@(posedge clock) disable iff (sys_rst)
      opFire && opCode == sec_pkg::OPC_F1_DN && loadIn && !wipeIn
      |=> lastCount == presetLimit && !lastFlag)
      else $error("load did not copy preset");

   AST_WRAP: assert property (@(posedge clock) disable iff (sys_rst)
      opFire && opCode == sec_pkg::OPC_F1_UD && upEdge && !downEdge && !wipeIn
      && curCount == sec_pkg::CNT_MAX |=> lastCount == sec_pkg::CNT_MIN)
      else $error("up/down counter did not wrap");

   AST_INIT: assert property (@(posedge clock)
      $fell(sys_rst) |-> flagMem == '0 && !running ##1 !running [*3])
      else $error("flags not cleared at power-up");

   AST_F2_STOP: assert property (@(posedge clock) disable iff (sys_rst)
      opFire && opCode == sec_pkg::OPC_F2_UP && !wipeIn && curCount == presetLimit
      |=> lastCount == $past(curCount) && lastFlag)
      else $error("second up counter passed preset");

   AST_F2_UD: assert property (@(posedge clock) disable iff (sys_rst)
      opFire && opCode == sec_pkg::OPC_F2_UD |=> lastAtPreset == (lastCount == presetLimit)
      && lastAtZero == (lastCount == sec_pkg::CNT_ZERO))
      else $error("preset or zero output wrong");

   AST_PRIO: assert property (@(posedge clock) disable iff (sys_rst)
      opFire && opCode == sec_pkg::OPC_F2_DN && loadIn |=> lastCount == presetLimit)
      else $error("load lost to count edge");

endmodule

`default_nettype wire

// ==== sim/sec_host_model.sv ====
// Bus master standing in for the controller program: one AHB-Lite single
// word transfer per request. Assumes hready is the slave's hreadyout.
`timescale 1ns/1ps
`default_nettype none

module sec_host_model (
   input  wire logic        clock,    // System clock
   input  wire logic        sys_rst,  // Synchronous reset, high
   input  wire logic        reqValid, // Request held until done
   input  wire logic        reqWrite, // Request is a write
   input  wire logic [31:0] reqAddr,  // Request byte address
   input  wire logic [31:0] reqData,  // Request write data
   output logic             reqDone,  // High until request drops
   output logic [31:0]      rspData,  // Read data of last transfer
   output logic             hsel,     // AHB select
   output logic [31:0]      haddr,    // AHB address
   output logic [1:0]       htrans,   // AHB transfer type
   output logic             hwrite,   // AHB write
   output logic [2:0]       hsize,    // AHB size
   output logic [31:0]      hwdata,   // AHB write data
   input  wire logic        hready,   // AHB ready
   input  wire logic [31:0] hrdata    // AHB read data
);
   logic [1:0] phase;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         phase   <= 2'h0;
         reqDone <= 1'h0;
         rspData <= 32'h0;
         hsel    <= 1'h0;
         haddr   <= 32'h0;
         htrans  <= 2'h0;
         hwrite  <= 1'h0;
         hsize   <= 3'h2;
         hwdata  <= 32'h0;
      end else begin
         case (phase)
            2'h0: if (reqValid && !reqDone) begin
               hsel   <= 1'h1;
               htrans <= 2'h2;
               haddr  <= reqAddr;
               hwrite <= reqWrite;
               phase  <= 2'h1;
            end
            2'h1: if (hready) begin
               htrans <= 2'h0;
               // Reads leave the data lines toggling, never the old value
               hwdata <= reqWrite ? reqData : ~hwdata;
               phase  <= 2'h2;
            end
            2'h2: if (hready) begin
               rspData <= hrdata;
               reqDone <= 1'h1;
               phase   <= 2'h3;
            end
            default: if (!reqValid) begin
               reqDone <= 1'h0;
               phase   <= 2'h0;
            end
         endcase
      end
   end
endmodule

`default_nettype wire

// ==== sim/tb_scan_event_counters.sv ====
// Self-checking bench for the scan event counter bank.
// Assumes the host model is the only bus master and drives the slave.
`timescale 1ns/1ps
`default_nettype none

`define SEC_CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end

module tb_scan_event_counters;
   typedef struct {
      logic        wr;
      logic [7:0]  addr;
      logic [31:0] data;
      logic [31:0] exp;
      logic [31:0] mask;
   } sec_row_t;

   localparam logic [31:0] MCF = 32'h0009ffff;
   localparam logic [31:0] MC  = 32'h0008ffff;
   localparam logic [31:0] MU  = 32'h000effff;
   localparam logic [31:0] MA  = 32'hffffffff;

   logic        clock = 1'h0;
   logic        sys_rst = 1'h1;
   logic        retainCounts = 1'h0;
   logic        reqValid = 1'h0;
   logic        reqWrite = 1'h0;
   logic [31:0] reqAddr = 32'h0;
   logic [31:0] reqData = 32'h0;
   wire logic        reqDone;
   wire logic [31:0] rspData;
   wire logic        hsel;
   wire logic [31:0] haddr;
   wire logic [1:0]  htrans;
   wire logic        hwrite;
   wire logic [2:0]  hsize;
   wire logic [31:0] hwdata;
   wire logic        hreadyout;
   wire logic        hresp;
   wire logic [31:0] hrdata;
   int          error_cnt = 0;
   int          check_count = 0;
   logic [31:0] rd;
   sec_row_t    rows[$];

   always #2.5 clock = ~clock;

   sec_scan_counters dut (
      .clock(clock), .sys_rst(sys_rst), .retainCounts(retainCounts), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

   sec_host_model host (
      .clock(clock), .sys_rst(sys_rst), .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
      .reqData(reqData), .reqDone(reqDone), .rspData(rspData), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata));

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clock);
      reqWrite <= wr;
      reqAddr  <= {24'h0, a};
      reqData  <= d;
      reqValid <= 1'h1;
      n = 0;
      do begin
         @(negedge clock);
         n++;
      end while (reqDone !== 1'h1 && n < 200);
      if (n >= 200) begin
         error_cnt++;
         complete_run();
      end
      q = rspData;
      @(posedge clock);
      reqValid <= 1'h0;
   endtask

   task automatic wait_run();
      int          n;
      logic [31:0] q;
      for (n = 0; n < 600; n++) begin
         bus(1'h0, sec_pkg::OFF_STATUS, 32'h0, q);
         if (q[sec_pkg::ST_RDY_BIT] === 1'h1) break;
      end
      if (n == 600) begin
         error_cnt++;
         complete_run();
      end
   endtask

   task automatic pulse_reset();
      @(posedge clock);
      sys_rst <= 1'h1;
      repeat (4) @(posedge clock);
      sys_rst <= 1'h0;
      wait_run();
   endtask

   initial begin
      rows = '{
         '{1'h1, 8'h04, 32'h00000002, 32'h0, 32'h0},
         '{1'h1, 8'h00, 32'h00010101, 32'h00080001, MCF},
         '{1'h1, 8'h00, 32'h00000101, 32'h00080001, MCF},
         '{1'h1, 8'h00, 32'h00010101, 32'h00090002, MCF},
         '{1'h1, 8'h08, 32'h00000001, 32'h0, 32'h0},
         '{1'h0, 8'h0c, 32'h0, 32'h00090002, MCF},
         '{1'h1, 8'h04, 32'h00007fff, 32'h0, 32'h0},
         '{1'h1, 8'h00, 32'h00040502, 32'h00087fff, MC},
         '{1'h1, 8'h04, 32'h00000000, 32'h0, 32'h0},
         '{1'h1, 8'h00, 32'h00010102, 32'h00097fff, MCF},
         '{1'h1, 8'h00, 32'h00000302, 32'h00097fff, MCF},
         '{1'h1, 8'h00, 32'h00010302, 32'h00088000, MCF},
         '{1'h1, 8'h00, 32'h00030302, 32'h00097fff, MCF},
         '{1'h1, 8'h04, 32'h00000002, 32'h0, 32'h0},
         '{1'h1, 8'h00, 32'h00040203, 32'h00080002, MCF},
         '{1'h1, 8'h00, 32'h00020203, 32'h00080001, MCF},
         '{1'h1, 8'h00, 32'h00000203, 32'h0, 32'h0},
         '{1'h1, 8'h00, 32'h00020203, 32'h00090000, MCF},
         '{1'h1, 8'h00, 32'h00000203, 32'h0, 32'h0},
         '{1'h1, 8'h00, 32'h00020203, 32'h00090000, MCF},
         '{1'h1, 8'h00, 32'h00000203, 32'h0, 32'h0},
         '{1'h1, 8'h00, 32'h00060203, 32'h00080002, MCF},
         '{1'h1, 8'h00, 32'h00080103, 32'h00080000, MCF},
         '{1'h1, 8'h00, 32'h00000701, 32'h00080000, MCF},
         '{1'h0, 8'h0c, 32'h0, 32'h00080000, MCF},
         '{1'h1, 8'h00, 32'h00010404, 32'h00080001, MCF},
         '{1'h1, 8'h00, 32'h00000404, 32'h0, 32'h0},
         '{1'h1, 8'h00, 32'h00010404, 32'h00090002, MCF},
         '{1'h1, 8'h00, 32'h00000404, 32'h0, 32'h0},
         '{1'h1, 8'h00, 32'h00010404, 32'h00090002, MCF},
         '{1'h1, 8'h00, 32'h00080404, 32'h00080000, MCF},
         '{1'h1, 8'h04, 32'h00000001, 32'h0, 32'h0},
         '{1'h1, 8'h00, 32'h00040505, 32'h00080001, MCF},
         '{1'h1, 8'h00, 32'h00020505, 32'h00090000, MCF},
         '{1'h1, 8'h00, 32'h00000505, 32'h0, 32'h0},
         '{1'h1, 8'h00, 32'h00020505, 32'h00090000, MCF},
         '{1'h1, 8'h04, 32'h00000002, 32'h0, 32'h0},
         '{1'h1, 8'h00, 32'h00040606, 32'h000a0002, MU},
         '{1'h1, 8'h00, 32'h00010606, 32'h000a0002, MU},
         '{1'h1, 8'h00, 32'h00020606, 32'h00080001, MU},
         '{1'h1, 8'h00, 32'h00000606, 32'h0, 32'h0},
         '{1'h1, 8'h00, 32'h00020606, 32'h000c0000, MU},
         '{1'h1, 8'h00, 32'h00000606, 32'h0, 32'h0},
         '{1'h1, 8'h00, 32'h00020606, 32'h000c0000, MU},
         '{1'h1, 8'h00, 32'h00040606, 32'h000a0002, MU},
         '{1'h1, 8'h00, 32'h000c0606, 32'h000c0000, MU},
         '{1'h1, 8'h08, 32'h00000006, 32'h0, 32'h0},
         '{1'h1, 8'h00, 32'h00010806, 32'h0, 32'h0},
         '{1'h0, 8'h0c, 32'h0, 32'h000c0000, MU},
         '{1'h0, 8'h04, 32'h0, 32'h00000002, 32'h0000ffff},
         '{1'h1, 8'h24, 32'h12345678, 32'h0, 32'h0},
         '{1'h0, 8'h24, 32'h0, 32'h0, MA},
         '{1'h0, 8'h00, 32'h0, 32'h0, MA}};
      repeat (4) @(posedge clock);
      sys_rst <= 1'h0;
      wait_run();
      foreach (rows[i]) begin
         if (rows[i].wr) bus(1'h1, rows[i].addr, rows[i].data, rd);
         if (rows[i].mask !== 32'h0) begin
            bus(1'h0, (rows[i].wr && rows[i].addr == sec_pkg::OFF_OP) ? sec_pkg::OFF_LAST : rows[i].addr,
                32'h0, rd);
            `SEC_CHK($sformatf("row %0d", i), rows[i].exp & rows[i].mask, rd & rows[i].mask)
         end
      end
      `SEC_CHK("bus response", 1'h0, hresp)
      // Counts cleared and flags off after a mid-run reset
      pulse_reset();
      bus(1'h1, sec_pkg::OFF_SEL, 32'h00000002, rd);
      bus(1'h0, sec_pkg::OFF_STATUS, 32'h0, rd);
      `SEC_CHK("status after reset", 32'h00080000, rd & 32'h000fffff)
      // Retained count survives reset while flags still clear
      bus(1'h1, sec_pkg::OFF_PRESET, 32'h00001234, rd);
      bus(1'h1, sec_pkg::OFF_OP, 32'h00040502, rd);
      bus(1'h1, sec_pkg::OFF_OP, 32'h00010102, rd);
      retainCounts <= 1'h1;
      pulse_reset();
      bus(1'h1, sec_pkg::OFF_SEL, 32'h00000002, rd);
      bus(1'h0, sec_pkg::OFF_STATUS, 32'h0, rd);
      `SEC_CHK("retained status", 32'h00081235, rd & MCF)
      complete_run();
   end
endmodule

`default_nettype wire
